// ==== core/tpw_pkg.sv ====
// Purpose: Shared constants and types for the three-phase PWM timer block.
// Assumes: Register indices are byte addresses divided by four on the bus.
// Notes: Field positions are bit numbers inside the 8-bit registers.
package tpw_pkg;

  // Bus widths.
  localparam int ADR_W = 16;
  localparam int DAT_W = 32;
  localparam int IDX_W = 13;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_TIMER_CTRL = 13'h1002;
  localparam logic [IDX_W-1:0] IDX_PWM_CTRL1 = 13'h1003;
  localparam logic [IDX_W-1:0] IDX_PWM_CTRL2 = 13'h1004;
  localparam logic [IDX_W-1:0] IDX_PWM_CTRL3 = 13'h1005;
  localparam logic [IDX_W-1:0] IDX_PERIOD_LOW = 13'h1008;
  localparam logic [IDX_W-1:0] IDX_PERIOD_HIGH = 13'h1009;
  localparam logic [IDX_W-1:0] IDX_DUTY_A_LOW = 13'h100a;
  localparam logic [IDX_W-1:0] IDX_DUTY_A_HIGH = 13'h100b;
  localparam logic [IDX_W-1:0] IDX_DUTY_B_LOW = 13'h100c;
  localparam logic [IDX_W-1:0] IDX_DUTY_B_HIGH = 13'h100d;
  localparam logic [IDX_W-1:0] IDX_DUTY_C_LOW = 13'h100e;
  localparam logic [IDX_W-1:0] IDX_DUTY_C_HIGH = 13'h100f;
  localparam logic [IDX_W-1:0] IDX_DELAY_A = 13'h1010;
  localparam logic [IDX_W-1:0] IDX_DELAY_B = 13'h1011;
  localparam logic [IDX_W-1:0] IDX_DELAY_C = 13'h1012;
  localparam logic [IDX_W-1:0] IDX_COMPARE = 13'h1013;
  localparam logic [IDX_W-1:0] IDX_CAPTURE = 13'h1014;
  localparam logic [IDX_W-1:0] IDX_COUNT = 13'h1015;

  // Reset values.
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_PERIOD_LOW = 8'hff;
  localparam logic [1:0] RST_HIGH = 2'h0;
  localparam logic [7:0] RST_DUTY_LOW = 8'h7f;
  localparam logic [7:0] RST_DELAY = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'hff;
  localparam logic [7:0] RST_CAPTURE = 8'h00;

  // Timer control fields.
  localparam int TC_CASCADE = 7;
  localparam int TC_CAPMODE = 6;
  localparam int TC_CONTINUE = 5;
  localparam int TC_START = 4;

  // PWM control one fields.
  localparam int P1_MODE = 7;
  localparam int P1_SYNC = 6;
  localparam int P1_UPDN = 5;
  localparam int P1_HALT = 4;
  localparam int P1_UPDSEL = 3;
  localparam int P1_UPDATE_ALL_DUTIES = 2;
  localparam int P1_DELAY_PRESCALER = 0;

  // PWM control two fields; pin enables sit in bits 5..0.
  localparam int P2_SINGLE = 7;

  // PWM control three fields; pin polarities sit in bits 5..0.
  localparam int P3_HIZ = 7;
  localparam int P3_SECLVL = 6;

  // Pin order: 5 a1, 4 a2, 3 b1, 2 b2, 1 c1, 0 c2.
  localparam int NPINS = 6;

  // Six PWM pins as level and output enable.
  typedef struct packed {
    logic [NPINS-1:0] level;
    logic [NPINS-1:0] oe;
  } tpw_pins_s;

endpackage

// ==== core/tpw_top.sv ====
// Purpose: Eight-bit timer that switches into a 10-bit three-channel PWM.
// Assumes: Classic Wishbone slave, one register per aligned word.
// Notes: Summary of operation follows.
// Summary of operation
// [RULE1] Ten-bit period split over high/low bytes.
// [RULE2] Three ten-bit duties, low resets 7f.
// [RULE3] Per-pin four-bit rising delay, prescaled.
// [RULE4] Timer reads live count, capture reads latch.
// [RULE5] Mode bit selects timer or PWM.
// [RULE6] Blank rising edge floats pins when synced.
// [RULE7] Up-only or up/down counting select.
// [RULE8] Update at period match or immediately.
// [RULE9] Release bit restores drive, self clears.
// [RULE10] Disabled second pin: polarity or first level.
// [RULE11] First pin polarity sets start, idle level.
// [RULE12] Second pin copies first, optionally inverted.
// [RULE13] Halt forces reset outputs, counter zero.
// [RULE14] Update-all writes A duty into B, C.
// [RULE15] Single-channel mode drives all from A.
// [RULE16] Six-channel mode uses own channel duty.
// [RULE17] Counter zero to period, toggle at duty.
// [RULE18] Bytes combined whole into active compare.
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module tpw_top
  import tpw_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Wishbone slave.
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [DAT_W-1:0] wb_dat_in,
  output logic [DAT_W-1:0] wb_dat_out,
  output logic wb_ack_out,
  // External pins.
  input wire logic blank_input_in,
  input wire logic capture_in,
  output tpw_pins_s pins_out
);

  // Bus state.
  logic ack_reg;
  logic [DAT_W-1:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [IDX_W-1:0] idx;
  logic mapped;
  logic wr_en;

  // Software registers.
  logic [7:0] timer_control_reg;
  logic [7:0] pwm_control_one_reg;
  logic [7:0] pwm_control_two_reg;
  logic [6:0] pwm_control_three_reg;
  logic [7:0] period_low_reg;
  logic [1:0] period_high_reg;
  logic [7:0] duty_low_reg [3];
  logic [1:0] duty_high_reg [3];
  logic [7:0] delay_reg [3];
  logic [7:0] compare_value_reg;
  logic [7:0] capture_value_reg;

  // Counter and active compare values.
  logic [9:0] cnt_reg;
  logic dir_up_reg;
  logic [9:0] period_act_reg;
  logic [9:0] duty_act_reg [3];
  logic period_match;
  logic load_active;

  // Pin synchronisers and edge history.
  logic blank_meta_reg;
  logic blank_sync_reg;
  logic blank_prev_reg;
  logic cap_meta_reg;
  logic cap_sync_reg;
  logic cap_prev_reg;
  logic hiz_reg;

  // Delay prescaler.
  logic [2:0] pre_reg;
  logic [2:0] pre_mask;
  logic delay_tick;

  // Per-pin levels.
  logic [NPINS-1:0] base_lvl;
  logic [NPINS-1:0] dly_lvl;
  logic [NPINS-1:0] pin_lvl;
  logic [2:0] chan_on;

  // Control decode.
  logic pwm_mode;
  logic pwm_hold;
  logic [7:0] pol;
  logic [5:0] pin_en;

  assign pwm_mode = pwm_control_one_reg[P1_MODE];
  assign pol = {1'b0, pwm_control_three_reg};
  assign pin_en = pwm_control_two_reg[5:0];

  // Halt, or a low blank level while synced, holds the PWM in reset.
  // [RULE13] halt holds counter
  assign pwm_hold = pwm_control_one_reg[P1_HALT] |
                    (pwm_control_one_reg[P1_SYNC] & ~blank_sync_reg);

  // Address decode; bit 15 set lands outside the map, address bits 1..0 are ignored.
  assign idx = wb_adr_in[IDX_W+1:2];
  assign wr_en = wb_cyc_in & wb_stb_in & wb_we_in & ~ack_reg & wb_sel_in[0];

  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    rdata_next = 8'h00;
    mapped = 1'b1;
    case (idx)
      IDX_TIMER_CTRL: rdata_next = timer_control_reg;
      IDX_PWM_CTRL1: rdata_next = pwm_control_one_reg;
      IDX_PWM_CTRL2: rdata_next = pwm_control_two_reg;
      IDX_PWM_CTRL3: rdata_next = {1'b0, pwm_control_three_reg};
      IDX_PERIOD_LOW: rdata_next = period_low_reg;
      IDX_PERIOD_HIGH: rdata_next = {6'h00, period_high_reg};
      IDX_DUTY_A_LOW: rdata_next = duty_low_reg[0];
      IDX_DUTY_A_HIGH: rdata_next = {6'h00, duty_high_reg[0]};
      IDX_DUTY_B_LOW: rdata_next = duty_low_reg[1];
      IDX_DUTY_B_HIGH: rdata_next = {6'h00, duty_high_reg[1]};
      IDX_DUTY_C_LOW: rdata_next = duty_low_reg[2];
      IDX_DUTY_C_HIGH: rdata_next = {6'h00, duty_high_reg[2]};
      IDX_DELAY_A: rdata_next = delay_reg[0];
      IDX_DELAY_B: rdata_next = delay_reg[1];
      IDX_DELAY_C: rdata_next = delay_reg[2];
      IDX_COMPARE: rdata_next = compare_value_reg;
      // [RULE4] capture latch read
      IDX_CAPTURE: rdata_next = capture_value_reg;
      // [RULE4] live count read
      IDX_COUNT: rdata_next = cnt_reg[7:0];
      default: mapped = 1'b0;
    endcase
    if (wb_adr_in[ADR_W-1] != 1'b0) begin
      rdata_next = 8'h00;
      mapped = 1'b0;
    end
  end

  // Acknowledge one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg <= wb_cyc_in & wb_stb_in & ~ack_reg;
      rdata_reg <= {24'h000000, rdata_next};
    end
  end

  assign wb_ack_out = ack_reg;
  assign wb_dat_out = rdata_reg;

  // Control and compare register writes.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      timer_control_reg <= RST_CTRL;
      pwm_control_one_reg <= RST_CTRL;
      pwm_control_two_reg <= RST_CTRL;
      pwm_control_three_reg <= RST_CTRL[6:0];
      compare_value_reg <= RST_COMPARE;
      delay_reg <= '{RST_DELAY, RST_DELAY, RST_DELAY};
    end else if (wr_en && mapped) begin
      case (idx)
        IDX_TIMER_CTRL: timer_control_reg <= wb_dat_in[7:0];
        // [RULE5] mode select write
        IDX_PWM_CTRL1: pwm_control_one_reg <= wb_dat_in[7:0];
        IDX_PWM_CTRL2: pwm_control_two_reg <= wb_dat_in[7:0];
        IDX_PWM_CTRL3: pwm_control_three_reg <= wb_dat_in[6:0];
        IDX_DELAY_A: delay_reg[0] <= wb_dat_in[7:0];
        IDX_DELAY_B: delay_reg[1] <= wb_dat_in[7:0];
        IDX_DELAY_C: delay_reg[2] <= wb_dat_in[7:0];
        IDX_COMPARE: compare_value_reg <= wb_dat_in[7:0];
        default: ;
      endcase
    end
  end

  // Period and duty byte writes.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      period_low_reg <= RST_PERIOD_LOW;
      period_high_reg <= RST_HIGH;
      duty_low_reg <= '{RST_DUTY_LOW, RST_DUTY_LOW, RST_DUTY_LOW};
      duty_high_reg <= '{RST_HIGH, RST_HIGH, RST_HIGH};
    end else if (wr_en && mapped) begin
      case (idx)
        // [RULE1] period byte halves
        IDX_PERIOD_LOW: period_low_reg <= wb_dat_in[7:0];
        IDX_PERIOD_HIGH: period_high_reg <= wb_dat_in[1:0];
        // [RULE14] update all duties
        IDX_DUTY_A_LOW: begin
          duty_low_reg[0] <= wb_dat_in[7:0];
          if (pwm_control_one_reg[P1_UPDATE_ALL_DUTIES]) begin
            duty_low_reg[1] <= wb_dat_in[7:0];
            duty_low_reg[2] <= wb_dat_in[7:0];
          end
        end
        IDX_DUTY_A_HIGH: begin
          duty_high_reg[0] <= wb_dat_in[1:0];
          if (pwm_control_one_reg[P1_UPDATE_ALL_DUTIES]) begin
            duty_high_reg[1] <= wb_dat_in[1:0];
            duty_high_reg[2] <= wb_dat_in[1:0];
          end
        end
        // [RULE2] duty byte halves
        IDX_DUTY_B_LOW: duty_low_reg[1] <= wb_dat_in[7:0];
        IDX_DUTY_B_HIGH: duty_high_reg[1] <= wb_dat_in[1:0];
        IDX_DUTY_C_LOW: duty_low_reg[2] <= wb_dat_in[7:0];
        IDX_DUTY_C_HIGH: duty_high_reg[2] <= wb_dat_in[1:0];
        default: ;
      endcase
    end
  end

  // Two-flop synchronisers and edge history for the pins.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      blank_meta_reg <= 1'b1;
      blank_sync_reg <= 1'b1;
      blank_prev_reg <= 1'b1;
      cap_meta_reg <= 1'b0;
      cap_sync_reg <= 1'b0;
      cap_prev_reg <= 1'b0;
    end else begin
      blank_meta_reg <= blank_input_in;
      blank_sync_reg <= blank_meta_reg;
      blank_prev_reg <= blank_sync_reg;
      cap_meta_reg <= capture_in;
      cap_sync_reg <= cap_meta_reg;
      cap_prev_reg <= cap_sync_reg;
    end
  end

  // High-impedance flag; a blank edge wins over a release write.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      hiz_reg <= 1'b0;
    end else if (pwm_control_one_reg[P1_SYNC] && blank_sync_reg && !blank_prev_reg) begin
      // [RULE6] blank edge floats
      hiz_reg <= 1'b1;
    end else if (wr_en && mapped && idx == IDX_PWM_CTRL3 && wb_dat_in[P3_HIZ]) begin
      // [RULE9] release restores drive
      hiz_reg <= 1'b0;
    end
  end

  // Capture latch on the synchronised capture edge.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      capture_value_reg <= RST_CAPTURE;
    end else if (!pwm_mode && timer_control_reg[TC_CAPMODE] && cap_sync_reg && !cap_prev_reg) begin
      // [RULE4] latch count
      capture_value_reg <= cnt_reg[7:0];
    end
  end

  // [RULE8] match or immediate load
  assign period_match = pwm_mode && (cnt_reg == period_act_reg);
  assign load_active = pwm_control_one_reg[P1_UPDSEL] | period_match;

  // Active compare values, loaded as whole 10-bit words.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      period_act_reg <= {RST_HIGH, RST_PERIOD_LOW};
      duty_act_reg <= '{{RST_HIGH, RST_DUTY_LOW}, {RST_HIGH, RST_DUTY_LOW},
                         {RST_HIGH, RST_DUTY_LOW}};
    end else if (load_active) begin
      // [RULE18] combine byte pairs
      period_act_reg <= {period_high_reg, period_low_reg};
      for (int i = 0; i < 3; i++) begin
        duty_act_reg[i] <= {duty_high_reg[i], duty_low_reg[i]};
      end
    end
  end

  // Shared counter for timer and PWM operation.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_reg <= 10'h000;
      dir_up_reg <= 1'b1;
    end else if (pwm_mode) begin
      if (pwm_hold) begin
        cnt_reg <= 10'h000;
        dir_up_reg <= 1'b1;
      end else if (pwm_control_one_reg[P1_UPDN]) begin
        // [RULE7] up and down
        if (dir_up_reg) begin
          if (cnt_reg >= period_act_reg) begin
            cnt_reg <= (period_act_reg == 10'h000) ? 10'h000 : cnt_reg - 10'h001;
            dir_up_reg <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg + 10'h001;
          end
        end else if (cnt_reg == 10'h000) begin
          cnt_reg <= (period_act_reg == 10'h000) ? 10'h000 : 10'h001;
          dir_up_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 10'h001;
        end
      end else begin
        // [RULE17] wrap at period
        cnt_reg <= (cnt_reg >= period_act_reg) ? 10'h000 : cnt_reg + 10'h001;
        dir_up_reg <= 1'b1;
      end
    end else begin
      // [RULE5] eight-bit timer
      dir_up_reg <= 1'b1;
      if (wr_en && mapped && idx == IDX_TIMER_CTRL && wb_dat_in[TC_START]) begin
        cnt_reg <= 10'h000;
      end else if (timer_control_reg[TC_CONTINUE]) begin
        if (cnt_reg[7:0] == compare_value_reg) begin
          cnt_reg <= 10'h000;
        end else begin
          cnt_reg <= {2'b00, cnt_reg[7:0] + 8'h01};
        end
      end
    end
  end

  // Delay prescaler; the tick fires once per 1, 2, 4 or 8 clocks.
  always_comb begin
    case (pwm_control_one_reg[P1_DELAY_PRESCALER +: 2])
      2'h0: pre_mask = 3'h0;
      2'h1: pre_mask = 3'h1;
      2'h2: pre_mask = 3'h3;
      default: pre_mask = 3'h7;
    endcase
  end

  // [RULE3] delay clock divider
  assign delay_tick = ((pre_reg & pre_mask) == pre_mask);

  // The prescaler restarts with each up-only period, so the delay tick keeps one
  // phase against the counter and a delayed pin has the same width in every period.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pre_reg <= 3'h0;
    end else if (pwm_mode && (pwm_hold || (!pwm_control_one_reg[P1_UPDN] &&
                 cnt_reg >= period_act_reg))) begin
      pre_reg <= 3'h0;
    end else begin
      pre_reg <= pre_reg + 3'h1;
    end
  end

  // Active phase of each channel, high while below its own duty, or below the A duty in single-channel mode.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      // [RULE16] own channel duty
      chan_on[i] = (cnt_reg < duty_act_reg[i]);
    end
    if (pwm_control_two_reg[P2_SINGLE]) begin
      // [RULE15] all from A
      chan_on = {3{cnt_reg < duty_act_reg[0]}};
    end
  end

  // Per-pin level, delay and enable handling.
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : gen_pin
      localparam int CH = (NPINS - 1 - g) / 2;
      localparam bit FIRST = (g % 2) == 1;
      logic [3:0] dly_cnt_reg;
      logic [3:0] dly_val;

      assign dly_val = FIRST ? delay_reg[CH][7:4] : delay_reg[CH][3:0];

      if (FIRST) begin : gen_first
        // [RULE11] polarity sets start
        assign base_lvl[g] = chan_on[CH] ^ pol[g];
      end else begin : gen_second
        // [RULE12] copy or invert first
        assign base_lvl[g] = chan_on[CH] ^ pol[g + 1] ^ pol[g];
      end

      // Count prescaled ticks while the level is high.
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          dly_cnt_reg <= 4'h0;
        end else if (!base_lvl[g]) begin
          dly_cnt_reg <= 4'h0;
        end else if (delay_tick && dly_cnt_reg != dly_val) begin
          dly_cnt_reg <= dly_cnt_reg + 4'h1;
        end
      end

      // [RULE3] rising edge delay
      assign dly_lvl[g] = base_lvl[g] && (dly_cnt_reg == dly_val);
    end
  endgenerate

  // Final pin levels; disabled pins take their polarity, or a second pin the first pin's level.
  always_comb begin
    pin_lvl = '0;
    for (int p = NPINS - 1; p >= 0; p--) begin
      if (!pwm_mode || pwm_hold) begin
        pin_lvl[p] = 1'b0;
      end else if (pin_en[p]) begin
        pin_lvl[p] = dly_lvl[p];
      end else if (p % 2 == 1) begin
        // [RULE11] idle at polarity
        pin_lvl[p] = pol[p];
      end else if (pwm_control_three_reg[P3_SECLVL]) begin
        // [RULE10] follow first pin
        pin_lvl[p] = pin_lvl[p + 1];
      end else begin
        // [RULE10] own polarity level
        pin_lvl[p] = pol[p];
      end
    end
  end

  // Registered pins; the enable drops while floating.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pins_out <= '{level: '0, oe: '1};
    end else begin
      pins_out.level <= pin_lvl;
      // [RULE6] float all pins
      pins_out.oe <= {NPINS{~hiz_reg}};
    end
  end

endmodule

`default_nettype wire

// ==== testbench/tpw_top_props.sv ====
// Purpose: Port checker for the three-phase PWM timer.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Shadows follow a few control bytes from taken bus writes.
`timescale 1ns/1ps
`default_nettype none
module tpw_top_props
  import tpw_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Bus side.
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [DAT_W-1:0] wb_dat_in,
  input wire logic [DAT_W-1:0] wb_dat_out,
  input wire logic wb_ack_out,
  // Pin side.
  input wire logic blank_input_in,
  input wire logic capture_in,
  input wire tpw_pins_s pins_out
);
  logic req;
  logic wr;
  logic [7:0] dly_reg;
  logic [7:0] p1_reg;
  logic [2:0] halt_reg;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // A request is taken at an edge while no answer is pending.
  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr = req && wb_we_in && wb_sel_in[0];
  // Shadows of the delay and first control bytes.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      dly_reg <= 8'h00;
      p1_reg <= 8'h00;
    end else if (wr && wb_adr_in == 16'h4040) begin
      dly_reg <= wb_dat_in[7:0];
    end else if (wr && wb_adr_in == 16'h400c) begin
      p1_reg <= wb_dat_in[7:0];
    end
  end
  // Counts cycles spent halted, saturating at four.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !p1_reg[P1_HALT]) begin
      halt_reg <= 3'h0;
    end else if (halt_reg != 3'h4) begin
      halt_reg <= halt_reg + 3'h1;
    end
  end
  chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  chk_ack_taken: assert property (req |=> wb_ack_out)
    else $error("no ack one cycle after request");
  chk_ack_spur: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
    else $error("ack without request");
  chk_dat_upper: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
    else $error("upper read data not zero");
  chk_unmapped_zero: assert property (req && !wb_we_in && wb_adr_in == 16'h4018
    |=> wb_dat_out == 32'h0) else $error("unmapped read not zero");
  chk_delay_readback: assert property (
    req && !wb_we_in && wb_adr_in == 16'h4040 |=> wb_dat_out == {24'h0, dly_reg})
    else $error("delay byte read back wrong");
  chk_oe_equal: assert property (pins_out.oe == 6'h00 || pins_out.oe == 6'h3f)
    else $error("output enables differ");
  chk_reset_pins: assert property ($fell(sys_rst_in) |->
    pins_out.level == 6'h00 && pins_out.oe == 6'h3f) else $error("bad pins after reset");
  chk_halt_zero: assert property (halt_reg == 3'h4 |-> pins_out.level == 6'h00)
    else $error("pins not at reset level while halted");
  chk_blank_float: assert property ($rose(blank_input_in) && p1_reg[P1_SYNC]
    |-> ##[2:8] pins_out.oe == 6'h00) else $error("blank edge did not float pins");
  chk_hiz_release: assert property (wr && wb_adr_in == 16'h4014 && wb_dat_in[7]
    |-> ##[1:3] pins_out.oe == 6'h3f) else $error("release did not drive pins");
  cov_write: cover property (wr);
  cov_float: cover property (pins_out.oe == 6'h00);
  cov_halt: cover property (halt_reg == 3'h4);
endmodule
bind tpw_top tpw_top_props u_props (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
  .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .blank_input_in(blank_input_in),
  .capture_in(capture_in), .pins_out(pins_out));
`default_nettype wire

// ==== testbench/tpw_gate_model.sv ====
// Purpose: Gate driver inputs seen behind the six PWM pins.
// Assumes: Pins are sampled once per system clock.
// Notes: A floating pin shows the inverse of its last driven level.
`timescale 1ns/1ps
`default_nettype none
module tpw_gate_model
  import tpw_pkg::*;
(
  // Clock.
  input wire logic clk_in,
  // Pins from the timer.
  input wire tpw_pins_s pins_in,
  // Levels at the driver inputs.
  output logic [NPINS-1:0] gate_out
);
  logic [NPINS-1:0] last_reg;
  // Remembers the last driven level of each pin.
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < NPINS; i++) begin
      if (pins_in.oe[i]) begin
        last_reg[i] <= pins_in.level[i];
      end
    end
  end
  // A released pin drifts so that a stale level is never trusted.
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      gate_out[i] = pins_in.oe[i] ? pins_in.level[i] : ~last_reg[i];
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tpw_top_test.sv ====
// Purpose: Self-checking bench for the three-phase PWM timer.
// Assumes: Period of ten cycles; pins settle within thirty cycles.
// Notes: Pin high times are counted over ten whole periods.
`timescale 1ns/1ps
`default_nettype none
module tpw_top_test
  import tpw_pkg::*;
();
  logic clk_in, sys_rst_in, cyc, stb, we, ack, blank, cap;
  logic [ADR_W-1:0] adr;
  logic [3:0] sel;
  logic [DAT_W-1:0] wdat, rdat;
  tpw_pins_s pins;
  logic [NPINS-1:0] gate;
  logic [7:0] q, c1;
  int miscompares, num_checks;
  int hi [NPINS];
  localparam logic [15:0] RA [18] = '{16'h4008, 16'h400c, 16'h4010, 16'h4014, 16'h4020,
    16'h4024, 16'h4028, 16'h402c, 16'h4030, 16'h4034, 16'h4038, 16'h403c, 16'h4040,
    16'h4044, 16'h4048, 16'h404c, 16'h4050, 16'h4018};
  localparam logic [7:0] RV [18] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h7f,
    8'h00, 8'h7f, 8'h00, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
  tpw_top u_tpw_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .blank_input_in(blank), .capture_in(cap),
    .pins_out(pins));
  tpw_gate_model u_tpw_gate_model (.clk_in(clk_in), .pins_in(pins), .gate_out(gate));
  // Compares one byte and counts the result.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic bus cycle, held until ack is sampled high.
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d,
      input logic s, output logic [7:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= {3'h0, s};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat[7:0];
    if (n >= 50) begin
      miscompares++;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b1, q);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 1'b1, q);
    chk(q, e);
  endtask
  // Lets settings land, then counts high cycles of every pin.
  task automatic measure();
    repeat (30) @(posedge clk_in);
    hi = '{default: 0};
    repeat (100) begin
      @(negedge clk_in);
      for (int i = 0; i < NPINS; i++) hi[i] += int'(gate[i]);
    end
    @(posedge clk_in);
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Free-running system clock.
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    tally_and_finish();
  end
  // Main sequence.
  initial begin
    sys_rst_in = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 16'h0;
    sel = 4'h0;
    wdat = 32'h0;
    blank = 1'b1;
    cap = 1'b0;
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 18; i++) rd_chk(RA[i], RV[i]);
    wr(16'h4040, 8'ha5);
    rd_chk(16'h4040, 8'ha5);
    bus(1'b1, 16'h4040, 8'h11, 1'b0, q);
    rd_chk(16'h4040, 8'ha5);
    wr(16'h4024, 8'hff);
    rd_chk(16'h4024, 8'h03);
    wr(16'h4050, 8'h55);
    rd_chk(16'h4050, 8'h00);
    wr(16'h4014, 8'h80);
    rd_chk(16'h4014, 8'h00);
    wr(16'h4008, 8'h30);
    bus(1'b0, 16'h4054, 8'h00, 1'b1, c1);
    bus(1'b0, 16'h4054, 8'h00, 1'b1, q);
    chk({7'h0, c1 != q}, 8'h01);
    wr(16'h4008, 8'h70);
    cap <= 1'b1;
    repeat (6) @(posedge clk_in);
    bus(1'b0, 16'h4050, 8'h00, 1'b1, c1);
    chk({7'h0, c1 != 8'h00}, 8'h01);
    wr(16'h4040, 8'h00);
    wr(16'h4024, 8'h00);
    wr(16'h4020, 8'h09);
    wr(16'h4028, 8'h04);
    wr(16'h4030, 8'h08);
    wr(16'h4038, 8'h04);
    wr(16'h4010, 8'h3f);
    wr(16'h400c, 8'h88);
    measure();
    chk(hi[5][7:0], 8'h28);
    chk(hi[4][7:0], 8'h28);
    chk(hi[3][7:0], 8'h50);
    wr(16'h4014, 8'h30);
    measure();
    chk(hi[5][7:0], 8'h3c);
    chk(hi[4][7:0], 8'h28);
    wr(16'h4014, 8'h00);
    wr(16'h4010, 8'hbf);
    measure();
    chk(hi[3][7:0], 8'h28);
    wr(16'h4010, 8'h2f);
    wr(16'h4014, 8'h10);
    measure();
    chk(hi[4][7:0], 8'h64);
    wr(16'h4014, 8'h50);
    measure();
    chk(hi[4][7:0], 8'h28);
    wr(16'h4010, 8'h0f);
    wr(16'h4014, 8'h20);
    measure();
    chk(hi[5][7:0], 8'h64);
    chk(hi[4][7:0], 8'h00);
    wr(16'h4014, 8'h00);
    wr(16'h4010, 8'h3f);
    wr(16'h4040, 8'h20);
    measure();
    chk(hi[5][7:0], 8'h14);
    chk(hi[4][7:0], 8'h28);
    wr(16'h4040, 8'h10);
    wr(16'h400c, 8'h89);
    measure();
    chk(hi[5][7:0], 8'h14);
    wr(16'h4040, 8'h00);
    wr(16'h400c, 8'h8c);
    wr(16'h4028, 8'h02);
    measure();
    chk(hi[3][7:0], 8'h14);
    chk(hi[1][7:0], 8'h14);
    rd_chk(16'h4030, 8'h02);
    wr(16'h400c, 8'h98);
    measure();
    for (int i = 0; i < NPINS; i++) chk(hi[i][7:0], 8'h00);
    rd_chk(16'h4054, 8'h00);
    wr(16'h400c, 8'hc8);
    repeat (20) @(posedge clk_in);
    blank <= 1'b0;
    repeat (5) @(posedge clk_in);
    blank <= 1'b1;
    repeat (10) @(posedge clk_in);
    chk({2'h0, pins.oe}, 8'h00);
    wr(16'h4014, 8'h80);
    repeat (3) @(posedge clk_in);
    chk({2'h0, pins.oe}, 8'h3f);
    wr(16'h400c, 8'h88);
    blank <= 1'b0;
    repeat (5) @(posedge clk_in);
    blank <= 1'b1;
    repeat (10) @(posedge clk_in);
    chk({2'h0, pins.oe}, 8'h3f);
    tally_and_finish();
  end
endmodule
`default_nettype wire
